// ### bench/edc_axi_model.sv
module edc_axi_model #(
   parameter logic [31:0] PTR = 32'h5A3C0F18
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire  [2:0]  wr_lim,
   input  wire  [2:0]  rd_lim,
   output logic        wr_busy,
   output logic        rd_busy,
   output logic [31:0] ptr
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] t_q;
   always @(posedge clk) begin
      t_q <= rst_n ? t_q + 2'h1 : 2'h0;
   end
   // a zero cap lets no request out, so the port must then look idle
   assign wr_busy = (wr_lim != 3'h0) && t_q[0];
   assign rd_busy = (rd_lim != 3'h0) && t_q[1];
   assign ptr = PTR;
endmodule

// ### bench/edc_dma_ctrl_assertions.sv
`include "edc_map.vh"
module edc_chk (
   input wire        I_CORE_CLK,
   input wire        I_RESETN,
   input wire [6:0]  I_ADDR,
   input wire [31:0] I_WDATA,
   input wire        I_WR,
   input wire        I_RD,
   input wire [31:0] O_RDATA,
   input wire [14:0] I_STATUS,
   input wire        I_LP_REQ,
   input wire        O_TX_RUN,
   input wire        O_RX_RUN,
   input wire        O_TX_FLUSH,
   input wire        O_IRQ,
   input wire        O_LP_ACK,
   input wire [2:0]  O_WR_OSR_LIMIT,
   input wire [2:0]  O_RD_OSR_LIMIT,
   input wire        O_BURST_ANY
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESETN);
   sequence op_wr_s; I_WR && I_ADDR == `EDC_ADDR_OP_MODE; endsequence
   sequence ax_wr_s; I_WR && I_ADDR == `EDC_ADDR_AXI_MODE; endsequence
   unmapped_read_a: assert property (
      I_RD && I_ADDR == 7'h03 |=> O_RDATA == 32'h0) else $error("hole read");
   tx_run_on_a: assert property (
      op_wr_s ##0 I_WDATA[13] |-> ##2 O_TX_RUN) else $error("tx not running");
   rx_run_off_a: assert property (
      op_wr_s ##0 !I_WDATA[1] |-> ##2 !O_RX_RUN) else $error("rx not halted");
   flush_pulse_a: assert property (
      $rose(O_TX_FLUSH) |=> O_TX_FLUSH ##1 !O_TX_FLUSH) else $error("flush len");
   osr_limit_a: assert property (ax_wr_s |-> ##2
      O_WR_OSR_LIMIT == $past(I_WDATA[22:20], 2) &&
      O_RD_OSR_LIMIT == $past(I_WDATA[18:16], 2)) else $error("osr caps");
   burst_any_a: assert property (
      ax_wr_s |-> ##2 O_BURST_ANY == $past(I_WDATA[0], 2)) else $error("any_burst_length");
   lp_refuse_a: assert property (
      O_LP_ACK |-> I_LP_REQ || $past(I_LP_REQ)) else $error("ack w/o request");
   irq_cause_a: assert property (
      O_IRQ |-> $past(I_STATUS) != 15'h0) else $error("irq w/o source");
endmodule
bind edc_dma_ctrl edc_chk chk (.I_CORE_CLK, .I_RESETN, .I_ADDR, .I_WDATA,
   .I_WR, .I_RD, .O_RDATA, .I_STATUS, .I_LP_REQ, .O_TX_RUN, .O_RX_RUN,
   .O_TX_FLUSH, .O_IRQ, .O_LP_ACK, .O_WR_OSR_LIMIT, .O_RD_OSR_LIMIT,
   .O_BURST_ANY);

// ### bench/ethernet_dma_control_test.sv
`include "edc_map.vh"
module ethernet_dma_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] PV = 32'h5A3C0F18;
   localparam logic [6:0]  OP = `EDC_ADDR_OP_MODE;
   localparam logic [6:0]  IE = `EDC_ADDR_IRQ_EN;
   localparam logic [6:0]  WD = `EDC_ADDR_RX_WDOG;
   localparam logic [6:0]  AX = `EDC_ADDR_AXI_MODE;
   logic        I_CORE_CLK, I_RESETN, I_WR, I_RD, I_RX_PKT, I_RX_DROP_NOBUF;
   logic        I_RX_MISS_APP, I_RX_CSUM_ERR, I_RX_FRAME_ERR, I_RX_RUNT_GOOD;
   logic        I_RX_FRAME_DONE, I_TX_FRAME_IN, I_TX_STATUS_DONE;
   logic        I_RX_BUF_AVAIL, I_LP_REQ, I_WAKE_ANY, I_WAKE_SPECIAL;
   logic [6:0]  I_ADDR;
   logic [31:0] I_WDATA;
   logic [14:0] I_STATUS;
   logic [13:0] I_RX_FIFO_LEVEL, I_TX_FIFO_LEVEL;
   wire         I_AXI_WR_BUSY, I_AXI_RD_BUSY, O_TX_RUN, O_RX_RUN, O_TX_FLUSH;
   wire         O_TX_START, O_TX_SECOND_OK, O_RX_RELEASE, O_RX_DROP, O_IRQ;
   wire         O_RX_FLUSH, O_FLOW_PAUSE, O_RX_DONE_SET, O_LP_ACK, O_LP_STATE;
   wire         O_BURST_ANY;
   wire [31:0]  O_RDATA, ptr;
   wire [2:0]   O_WR_OSR_LIMIT, O_RD_OSR_LIMIT;
   wire [7:0]   O_BURST_ALLOW;
   int          failures = 0, n_checks = 0, cyc = 0, n;
   logic [6:0]  ma[5] = '{OP, IE, WD, AX, 7'h03};
   logic [31:0] mv[5] = '{32'h07E1FFDE, 32'h0001E7FF, 32'hFF, 32'hC07700FF, 0};
   logic [13:0] tx_t[8] = '{64, 128, 192, 256, 40, 32, 24, 16};
   logic [13:0] rx_t[4] = '{64, 32, 96, 128};
   edc_dma_ctrl dut (.I_CORE_CLK, .I_RESETN, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
      .O_RDATA, .I_STATUS, .I_RX_PKT, .I_RX_DROP_NOBUF, .I_RX_MISS_APP,
      .I_RX_CSUM_ERR, .I_RX_FRAME_ERR, .I_RX_RUNT_GOOD, .I_RX_FRAME_DONE,
      .I_RX_FIFO_LEVEL, .I_TX_FIFO_LEVEL, .I_TX_FRAME_IN, .I_TX_STATUS_DONE,
      .I_RX_BUF_AVAIL, .I_LP_REQ, .I_WAKE_ANY, .I_WAKE_SPECIAL,
      .I_AXI_WR_BUSY, .I_AXI_RD_BUSY, .I_CUR_TX_DESC(ptr), .I_CUR_RX_DESC(ptr),
      .I_CUR_TX_BUF(ptr), .I_CUR_RX_BUF(ptr), .O_TX_RUN, .O_RX_RUN,
      .O_TX_FLUSH, .O_TX_START, .O_TX_SECOND_OK, .O_RX_RELEASE, .O_RX_DROP,
      .O_RX_FLUSH, .O_FLOW_PAUSE, .O_IRQ, .O_RX_DONE_SET, .O_LP_ACK,
      .O_LP_STATE, .O_WR_OSR_LIMIT, .O_RD_OSR_LIMIT, .O_BURST_ALLOW,
      .O_BURST_ANY);
   edc_axi_model #(.PTR(PV)) far (.clk(I_CORE_CLK), .rst_n(I_RESETN),
      .wr_lim(O_WR_OSR_LIMIT), .rd_lim(O_RD_OSR_LIMIT),
      .wr_busy(I_AXI_WR_BUSY), .rd_busy(I_AXI_RD_BUSY), .ptr(ptr));
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // drivers move 1 ns after the edge so no sample races the design
   task automatic cw(input int k);
      repeat (k) @(posedge I_CORE_CLK);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t word %h want %h", $time, got, exp);
      end
   endtask
   task automatic chf(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] v);
      I_ADDR <= a;
      I_WDATA <= v;
      I_WR <= 1'b1;
      cw(1);
      I_WR <= 1'b0;
      cw(1);
   endtask
   task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
      I_ADDR <= a;
      I_RD <= 1'b1;
      cw(1);
      I_RD <= 1'b0;
      chk(O_RDATA, exp);
      cw(1);
   endtask
   initial begin
      I_CORE_CLK = 1'b0;
      forever #12.5 I_CORE_CLK = ~I_CORE_CLK;
   end
   always @(posedge I_CORE_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      {I_RESETN, I_WR, I_RD, I_RX_PKT, I_RX_DROP_NOBUF, I_RX_MISS_APP,
       I_RX_CSUM_ERR, I_RX_FRAME_ERR, I_RX_RUNT_GOOD, I_RX_FRAME_DONE,
       I_TX_FRAME_IN, I_TX_STATUS_DONE, I_RX_BUF_AVAIL, I_LP_REQ, I_WAKE_ANY,
       I_WAKE_SPECIAL, I_ADDR, I_WDATA, I_STATUS, I_RX_FIFO_LEVEL,
       I_TX_FIFO_LEVEL} = '0;
      repeat (5) @(posedge I_CORE_CLK);
      I_RESETN <= 1'b1;
      cw(1);
      foreach (ma[k]) rdc(ma[k], 32'h0);
      foreach (ma[k]) begin
         wr(ma[k], 32'hFFFFFFFF);
         cw(3);
         rdc(ma[k], mv[k]);
      end
      chk({24'h0, O_BURST_ALLOW}, 32'hFF);
      wr(7'h48, 32'h0);
      rdc(7'h48, PV);
      wr(OP, 32'h0);
      cw(1);
      chf(O_TX_RUN, 1'b0);
      wr(OP, 32'h2002);
      cw(1);
      chf(O_RX_RUN, 1'b1);
      for (n = 0; n < 8; n++) begin
         // flush clears the pending tx status wait left by the last start
         I_TX_FIFO_LEVEL <= tx_t[n] - 14'h1;
         I_RX_FIFO_LEVEL <= rx_t[n % 4] - 14'h1;
         wr(OP, 32'h00102002 | (n << 14) | ((n % 4) << 3));
         cw(3);
         chf(O_TX_START, 1'b0);
         chf(O_RX_RELEASE, 1'b0);
         I_TX_FIFO_LEVEL <= tx_t[n] + 14'h1;
         I_RX_FIFO_LEVEL <= rx_t[n % 4] + 14'h1;
         cw(1);
         chf(O_TX_START, 1'b1);
         cw(2);
         chf(O_RX_RELEASE, 1'b1);
      end
      wr(OP, 32'h00302000);
      cw(1);
      chf(O_TX_START, 1'b0);
      I_TX_FRAME_IN <= 1'b1;
      cw(1);
      chf(O_TX_START, 1'b1);
      cw(2);
      wr(OP, 32'h100);
      I_RX_FIFO_LEVEL <= 14'd7168;
      cw(3);
      chf(O_FLOW_PAUSE, 1'b1);
      I_RX_FIFO_LEVEL <= 14'h0;
      cw(3);
      chf(O_FLOW_PAUSE, 1'b0);
      wr(OP, 32'h00800702);
      I_RX_FIFO_LEVEL <= 14'h1FFF;
      cw(3);
      chf(O_FLOW_PAUSE, 1'b0);
      for (n = 0; n < 3; n++) begin
         I_RX_DROP_NOBUF <= 1'b1;
         I_RX_MISS_APP <= (n < 2);
         cw(1);
         {I_RX_DROP_NOBUF, I_RX_MISS_APP} <= 2'b00;
         cw(1);
      end
      rdc(7'h02, 32'h00040003);
      rdc(7'h02, 32'h0);
      wr(IE, 32'h00010001);
      I_STATUS <= 15'h0002;
      cw(3);
      chf(O_IRQ, 1'b0);
      I_STATUS <= 15'h0001;
      cw(3);
      chf(O_IRQ, 1'b1);
      wr(IE, 32'h1);
      cw(1);
      chf(O_IRQ, 1'b0);
      I_STATUS <= 15'h0;
      wr(AX, 32'h0);
      I_LP_REQ <= 1'b1;
      cw(3);
      chf(O_LP_ACK, 1'b0);
      wr(AX, 32'h80000000);
      cw(2);
      chf(O_LP_ACK, 1'b1);
      chf(O_LP_STATE, 1'b1);
      I_LP_REQ <= 1'b0;
      wr(AX, 32'hC0000000);
      I_WAKE_ANY <= 1'b1;
      cw(1);
      I_WAKE_ANY <= 1'b0;
      cw(2);
      chf(O_LP_STATE, 1'b1);
      I_WAKE_SPECIAL <= 1'b1;
      cw(1);
      I_WAKE_SPECIAL <= 1'b0;
      cw(2);
      chf(O_LP_STATE, 1'b0);
      wr(WD, 32'h1);
      I_RX_PKT <= 1'b1;
      cw(1);
      I_RX_PKT <= 1'b0;
      cw(240);
      chf(O_RX_DONE_SET, 1'b0);
      for (n = 0; n < 40 && O_RX_DONE_SET !== 1'b1; n++) cw(1);
      chf(n < 40, 1'b1);
      end_sim();
   end
endmodule

// ### verilog/edc_dma_ctrl.v
// What this block does
// - keep bit set: checksum-failed frames are kept, not dropped
// - rx full-frame mode: release frame only once wholly in fifo
// - no-flush bit set: never flush rx frames when buffers unavailable
// - flow thresholds: 3-bit code, max 8KB minus 1..7KB, 111 reserved
// - tx full-frame mode: start sending only when whole frame is in fifo
// - tx flush bit resets tx control and discards tx fifo data
// - tx threshold code selects 64,128,192,256,40,32,24,16 bytes
// - tx run bit: running when set, halted when clear
// - hardware flow control active when enable bit set
// - pass error frames; pass good frames under 64 bytes
// - rx threshold code selects 64,32,96,128 bytes
// - overlap bit allows second tx frame before first status written
// - rx run bit: running when set, halted when clear
// - summary enables gate normal and abnormal interrupt summaries
// - each status source except bits 11 and 12 has its own interrupt enable bit
// - 16-bit buffer-unavailable drop counter with overflow flag
// - 11-bit app missed-frame counter with fifo overflow flag
// - rx irq watchdog in 256-clock units sets rx done flag on timeout
// - low power requests accepted only when port enable set
// - wake restriction: only magic or remote wake packet wakes
// - 3-bit caps on outstanding axi write and read requests
// - burst length allow bits and undefined-length bit
`include "edc_map.vh"
module edc_dma_ctrl #(
   parameter ADDR_W = 7
) (
   input  wire              I_CORE_CLK,
   input  wire              I_RESETN,
   input  wire [ADDR_W-1:0] I_ADDR,
   input  wire [31:0]       I_WDATA,
   input  wire              I_WR,
   input  wire              I_RD,
   output reg  [31:0]       O_RDATA,
   input  wire [14:0]       I_STATUS,
   input  wire              I_RX_PKT,
   input  wire              I_RX_DROP_NOBUF,
   input  wire              I_RX_MISS_APP,
   input  wire              I_RX_CSUM_ERR,
   input  wire              I_RX_FRAME_ERR,
   input  wire              I_RX_RUNT_GOOD,
   input  wire              I_RX_FRAME_DONE,
   input  wire [13:0]       I_RX_FIFO_LEVEL,
   input  wire [13:0]       I_TX_FIFO_LEVEL,
   input  wire              I_TX_FRAME_IN,
   input  wire              I_TX_STATUS_DONE,
   input  wire              I_RX_BUF_AVAIL,
   input  wire              I_LP_REQ,
   input  wire              I_WAKE_ANY,
   input  wire              I_WAKE_SPECIAL,
   input  wire              I_AXI_WR_BUSY,
   input  wire              I_AXI_RD_BUSY,
   input  wire [31:0]       I_CUR_TX_DESC,
   input  wire [31:0]       I_CUR_RX_DESC,
   input  wire [31:0]       I_CUR_TX_BUF,
   input  wire [31:0]       I_CUR_RX_BUF,
   output reg               O_TX_RUN,
   output reg               O_RX_RUN,
   output reg               O_TX_FLUSH,
   output reg               O_TX_START,
   output reg               O_TX_SECOND_OK,
   output reg               O_RX_RELEASE,
   output reg               O_RX_DROP,
   output reg               O_RX_FLUSH,
   output reg               O_FLOW_PAUSE,
   output reg               O_IRQ,
   output reg               O_RX_DONE_SET,
   output reg               O_LP_ACK,
   output reg               O_LP_STATE,
   output reg  [2:0]        O_WR_OSR_LIMIT,
   output reg  [2:0]        O_RD_OSR_LIMIT,
   output reg  [7:0]        O_BURST_ALLOW,
   output reg               O_BURST_ANY
);
   reg [31:0] op_q;
   reg [31:0] ie_q;
   reg [31:0] wd_q;
   reg [31:0] ax_q;
   reg [15:0] nobuf_cnt_q;
   reg        nobuf_ovf_q;
   reg [10:0] miss_cnt_q;
   reg        miss_ovf_q;
   reg [7:0]  unit_q;
   reg [7:0]  wd_cnt_q;
   reg        wd_run_q;
   reg        rx_done_q;
   reg        tx_sent_q;
   reg        tx_wait_status_q;
   reg        flow_on_q;
   reg        pend_rx_q;
   reg [31:0] rdata_d;

   // fifo depth 8KB in bytes; code 111 is reserved and taken as "never"
   function [13:0] flow_level;
      input [2:0] code;
      begin
         if (code == 3'h7)
            flow_level = 14'h3FFF;
         else
            flow_level = ({11'h000, code} + 14'h0001) * 14'h0400;
      end
   endfunction

   function [8:0] tx_bytes;
      input [2:0] code;
      begin
         case (code)
            3'h0: tx_bytes = 9'h040;
            3'h1: tx_bytes = 9'h080;
            3'h2: tx_bytes = 9'h0C0;
            3'h3: tx_bytes = 9'h100;
            3'h4: tx_bytes = 9'h028;
            3'h5: tx_bytes = 9'h020;
            3'h6: tx_bytes = 9'h018;
            default: tx_bytes = 9'h010;
         endcase
      end
   endfunction

   function [7:0] rx_bytes;
      input [1:0] code;
      begin
         case (code)
            2'h0: rx_bytes = 8'h40;
            2'h1: rx_bytes = 8'h20;
            2'h2: rx_bytes = 8'h60;
            default: rx_bytes = 8'h80;
         endcase
      end
   endfunction

   wire [2:0]  on_code  = {op_q[`EDC_OM_ON_MSB], op_q[10:9]};
   wire [2:0]  off_code = {op_q[`EDC_OM_OFF_MSB], op_q[12:11]};
   wire [13:0] fifo_max = `EDC_FIFO_MAX_BYTES;
   wire [13:0] on_lvl   = fifo_max - flow_level(on_code);
   wire [13:0] off_lvl  = fifo_max - flow_level(off_code);
   wire [8:0]  tx_threshold      = tx_bytes(op_q[16:14]);
   wire [7:0]  rtc      = rx_bytes(op_q[4:3]);
   wire        wr_op    = I_WR && (I_ADDR == `EDC_ADDR_OP_MODE);
   wire        flush_now = wr_op && I_WDATA[`EDC_OM_TX_FLUSH];
   // normal sources: rx done, tx buf unavail, tx done, early rx
   wire [14:0] ev       = I_STATUS & ie_q[14:0];
   wire        norm     = ev[6] | ev[2] | ev[0] | ev[14];
   wire        abn      = |(ev & 15'h3FBA);

   // register writes; reserved bits masked off
   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         op_q <= `EDC_RESET_VAL;
         ie_q <= `EDC_RESET_VAL;
         wd_q <= `EDC_RESET_VAL;
         ax_q <= `EDC_RESET_VAL;
      end else begin
         if (wr_op)
            op_q <= I_WDATA & `EDC_OP_MODE_MASK;
         else if (op_q[`EDC_OM_TX_FLUSH])
            op_q[`EDC_OM_TX_FLUSH] <= 1'b0; // self clearing
         if (I_WR && I_ADDR == `EDC_ADDR_IRQ_EN)
            ie_q <= I_WDATA & `EDC_IRQ_EN_MASK;
         if (I_WR && I_ADDR == `EDC_ADDR_RX_WDOG)
            wd_q <= I_WDATA & `EDC_RX_WDOG_MASK;
         if (I_WR && I_ADDR == `EDC_ADDR_AXI_MODE)
            ax_q <= I_WDATA & `EDC_AXI_MODE_MASK;
      end
   end

   // missed frame counters, clear on read
   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         nobuf_cnt_q <= 16'h0000;
         nobuf_ovf_q <= 1'b0;
         miss_cnt_q  <= 11'h000;
         miss_ovf_q  <= 1'b0;
      end else begin
         if (I_RD && I_ADDR == `EDC_ADDR_MISSED) begin
            nobuf_cnt_q <= {15'h0000, I_RX_DROP_NOBUF};
            nobuf_ovf_q <= 1'b0;
            miss_cnt_q  <= {10'h000, I_RX_MISS_APP};
            miss_ovf_q  <= 1'b0;
         end else begin
            if (I_RX_DROP_NOBUF) begin
               nobuf_cnt_q <= nobuf_cnt_q + 16'h0001;
               if (nobuf_cnt_q == 16'hFFFF)
                  nobuf_ovf_q <= 1'b1;
            end
            if (I_RX_MISS_APP) begin
               miss_cnt_q <= miss_cnt_q + 11'h001;
               if (miss_cnt_q == 11'h7FF)
                  miss_ovf_q <= 1'b1;
            end
         end
      end
   end

   // rx interrupt watchdog: 256-cycle prescaler plus unit counter
   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         unit_q    <= 8'h00;
         wd_cnt_q  <= 8'h00;
         wd_run_q  <= 1'b0;
         rx_done_q <= 1'b0;
      end else begin
         rx_done_q <= I_STATUS[6];
         if (I_STATUS[6] || rx_done_q) begin
            wd_run_q <= 1'b0;
            wd_cnt_q <= 8'h00;
            unit_q   <= 8'h00;
         end else if (I_RX_PKT && !wd_run_q && wd_q[7:0] != 8'h00) begin
            wd_run_q <= 1'b1;
            wd_cnt_q <= 8'h00;
            unit_q   <= 8'h00;
         end else if (wd_run_q) begin
            unit_q <= unit_q + 8'h01;
            if (unit_q == 8'hFF)
               wd_cnt_q <= wd_cnt_q + 8'h01;
         end
      end
   end

   // tx path control
   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN || flush_now) begin
         tx_sent_q        <= 1'b0;
         tx_wait_status_q <= 1'b0;
      end else begin
         if (O_TX_START)
            tx_wait_status_q <= 1'b1;
         else if (I_TX_STATUS_DONE)
            tx_wait_status_q <= 1'b0;
         tx_sent_q <= O_TX_START;
      end
   end

   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         flow_on_q <= 1'b0;
         pend_rx_q <= 1'b0;
      end else begin
         if (!op_q[`EDC_OM_HW_FLOW])
            flow_on_q <= 1'b0;
         else if (I_RX_FIFO_LEVEL >= on_lvl)
            flow_on_q <= 1'b1;
         else if (I_RX_FIFO_LEVEL < off_lvl)
            flow_on_q <= 1'b0;
         pend_rx_q <= I_RX_FRAME_DONE;
      end
   end

   always @* begin
      rdata_d = 32'h00000000;
      case (I_ADDR)
         `EDC_ADDR_MISSED: rdata_d = {3'h0, miss_ovf_q, miss_cnt_q,
                                      nobuf_ovf_q, nobuf_cnt_q};
         `EDC_ADDR_CUR_TX_BUF:  rdata_d = I_CUR_TX_BUF;
         `EDC_ADDR_OP_MODE:     rdata_d = op_q;
         `EDC_ADDR_IRQ_EN:      rdata_d = ie_q;
         `EDC_ADDR_RX_WDOG:     rdata_d = wd_q;
         `EDC_ADDR_AXI_MODE:    rdata_d = ax_q;
         `EDC_ADDR_AXI_STAT:    rdata_d = {30'h0, I_AXI_RD_BUSY,
                                           I_AXI_WR_BUSY};
         `EDC_ADDR_CUR_TX_DESC: rdata_d = I_CUR_TX_DESC;
         `EDC_ADDR_CUR_RX_DESC: rdata_d = I_CUR_RX_DESC;
         `EDC_ADDR_CUR_RX_BUF:  rdata_d = I_CUR_RX_BUF;
         default:               rdata_d = 32'h00000000;
      endcase
   end

   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         O_RDATA        <= 32'h00000000;
         O_TX_RUN       <= 1'b0;
         O_RX_RUN       <= 1'b0;
         O_TX_FLUSH     <= 1'b0;
         O_TX_START     <= 1'b0;
         O_TX_SECOND_OK <= 1'b0;
         O_RX_RELEASE   <= 1'b0;
         O_RX_DROP      <= 1'b0;
         O_RX_FLUSH     <= 1'b0;
         O_FLOW_PAUSE   <= 1'b0;
         O_IRQ          <= 1'b0;
         O_RX_DONE_SET  <= 1'b0;
         O_LP_ACK       <= 1'b0;
         O_LP_STATE     <= 1'b0;
         O_WR_OSR_LIMIT <= 3'h0;
         O_RD_OSR_LIMIT <= 3'h0;
         O_BURST_ALLOW  <= 8'h00;
         O_BURST_ANY    <= 1'b0;
      end else begin
         O_RDATA    <= I_RD ? rdata_d : 32'h00000000;
         O_TX_RUN   <= op_q[`EDC_OM_TX_RUN];
         O_RX_RUN   <= op_q[`EDC_OM_RX_RUN];
         O_TX_FLUSH <= flush_now | op_q[`EDC_OM_TX_FLUSH];
         // start when full frame in (store-forward) or threshold met
         O_TX_START <= O_TX_RUN && !tx_sent_q && !flush_now &&
            (op_q[`EDC_OM_OVERLAP] || !tx_wait_status_q) &&
            (op_q[`EDC_OM_TX_FULL] ? I_TX_FRAME_IN :
             (I_TX_FRAME_IN || I_TX_FIFO_LEVEL >= {5'h00, tx_threshold}));
         O_TX_SECOND_OK <= op_q[`EDC_OM_OVERLAP] || !tx_wait_status_q;
         O_RX_RELEASE <= O_RX_RUN &&
            (op_q[`EDC_OM_RX_FULL] ? pend_rx_q :
             (pend_rx_q || I_RX_FIFO_LEVEL >= {6'h00, rtc}));
         O_RX_DROP <= (I_RX_CSUM_ERR && !op_q[`EDC_OM_KEEP_CSUM]) ||
            (I_RX_FRAME_ERR && !op_q[`EDC_OM_PASS_ERR]) ||
            (I_RX_RUNT_GOOD && !op_q[`EDC_OM_PASS_RUNT]);
         O_RX_FLUSH <= !I_RX_BUF_AVAIL && !op_q[`EDC_OM_NO_FLUSH];
         O_FLOW_PAUSE <= flow_on_q;
         O_IRQ <= (norm && ie_q[`EDC_IE_NORMAL]) ||
                  (abn && ie_q[`EDC_IE_ABNORMAL]);
         O_RX_DONE_SET <= wd_run_q && !rx_done_q && !I_STATUS[6] &&
            wd_q[7:0] != 8'h00 && unit_q == 8'hFF &&
            wd_cnt_q + 8'h01 >= wd_q[7:0];
         O_LP_ACK <= I_LP_REQ && ax_q[`EDC_AX_LP_EN];
         if (I_LP_REQ && ax_q[`EDC_AX_LP_EN])
            O_LP_STATE <= 1'b1;
         else if (ax_q[`EDC_AX_WAKE_SPECIAL] ? I_WAKE_SPECIAL :
                  (I_WAKE_ANY || I_WAKE_SPECIAL))
            O_LP_STATE <= 1'b0;
         O_WR_OSR_LIMIT <= ax_q[22:20];
         O_RD_OSR_LIMIT <= ax_q[18:16];
         O_BURST_ALLOW  <= {ax_q[7:1], 1'b1};
         O_BURST_ANY    <= ax_q[`EDC_AX_ANY_BURST_LENGTH];
      end
   end
endmodule

// ### verilog/edc_map.vh
`ifndef EDC_MAP_VH
`define EDC_MAP_VH
// register addresses on the plain register port (7-bit word index)
`define EDC_ADDR_MISSED      7'h02
`define EDC_ADDR_CUR_TX_BUF  7'h05
`define EDC_ADDR_OP_MODE     7'h18
`define EDC_ADDR_IRQ_EN      7'h1C
`define EDC_ADDR_RX_WDOG     7'h24
`define EDC_ADDR_AXI_MODE    7'h28
`define EDC_ADDR_AXI_STAT    7'h2C
`define EDC_ADDR_CUR_TX_DESC 7'h48
`define EDC_ADDR_CUR_RX_DESC 7'h4C
`define EDC_ADDR_CUR_RX_BUF  7'h54
// writable bit masks; reserved bits read zero
`define EDC_OP_MODE_MASK     32'h07F1FFDE
`define EDC_IRQ_EN_MASK      32'h0001E7FF
`define EDC_RX_WDOG_MASK     32'h000000FF
`define EDC_AXI_MODE_MASK    32'hC07700FF
`define EDC_RESET_VAL        32'h00000000
// operation mode fields
`define EDC_OM_KEEP_CSUM     26
`define EDC_OM_RX_FULL       25
`define EDC_OM_NO_FLUSH      24
`define EDC_OM_ON_MSB        23
`define EDC_OM_OFF_MSB       22
`define EDC_OM_TX_FULL       21
`define EDC_OM_TX_FLUSH      20
`define EDC_OM_TX_RUN        13
`define EDC_OM_HW_FLOW       8
`define EDC_OM_PASS_ERR      7
`define EDC_OM_PASS_RUNT     6
`define EDC_OM_OVERLAP       2
`define EDC_OM_RX_RUN        1
// interrupt enable fields
`define EDC_IE_NORMAL        16
`define EDC_IE_ABNORMAL      15
// axi bus mode fields
`define EDC_AX_LP_EN         31
`define EDC_AX_WAKE_SPECIAL  30
`define EDC_AX_ANY_BURST_LENGTH         0
// sizes and timing
`define EDC_FIFO_MAX_KB      8
`define EDC_FIFO_MAX_BYTES   14'h2000
`define EDC_KB               1024
`define EDC_WDOG_UNIT        256
`define EDC_RUNT_BYTES       64
`endif
